// [ioc_pkg.sv]
package ioc_pkg;
  // ------------------------------------------------------------
  // data path
  // ------------------------------------------------------------
  localparam int NUM_CORES     = 4;
  localparam int CORE_IDX_W    = 2;
  localparam int SAMPLE_W      = 14;
  localparam int NUM_CHAN      = 2;
  localparam int ACC_FRAC_W    = 10;
  // ------------------------------------------------------------
  // control access
  // ------------------------------------------------------------
  localparam logic [7:0]  PAGE_CHAN_A   = 8'h00;
  localparam logic [7:0]  PAGE_CHAN_B   = 8'h01;
  localparam logic [15:0] CORR_CTRL_ADR = 16'h6068;
  localparam logic [7:0]  CODE_FREEZE   = 8'hC2;
  localparam logic [7:0]  CODE_BYPASS   = 8'hC3;
  localparam logic [7:0]  CODE_RUN      = 8'h00;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_PAGE      = 8'h00;
  localparam logic        RST_FREEZE    = 1'b0;
  localparam logic        RST_BYPASS    = 1'b0;
  localparam logic [1:0]  RST_CORE_IDX  = 2'h0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam real CLK_MHZ         = 25.0;
  localparam real EST_TIME_MS     = 0.4;
  localparam int  EST_TIME_CYCLES = int'($ceil(EST_TIME_MS * 1000.0 * CLK_MHZ));
endpackage : ioc_pkg

// [ioc_core_lane.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// one offset estimate for one interleaved core
// ------------------------------------------------------------
module ioc_core_lane #(
  parameter int SAMPLE_W = ioc_pkg::SAMPLE_W,
  parameter int FRAC_W   = ioc_pkg::ACC_FRAC_W
) (
  input  wire logic                i_ref_clk,  // sample clock
  input  wire logic                i_sys_rst,  // async reset, high
  input  wire logic                i_update,   // sample of this core present, estimate may move
  input  wire logic [SAMPLE_W-1:0] i_sample,   // signed raw sample
  output logic      [SAMPLE_W-1:0] o_offset    // current signed estimate
);
  localparam int ACC_W = SAMPLE_W + FRAC_W;

  logic signed [ACC_W-1:0] acc_ff;
  logic signed [ACC_W-1:0] nxt_acc;
  logic signed [ACC_W:0]   step;

  // leaky first-order average; long constant rejects wideband signal
  always_comb begin
    step    = {{(FRAC_W+1){i_sample[SAMPLE_W-1]}}, i_sample}
              - {{1{acc_ff[ACC_W-1]}}, (acc_ff >>> FRAC_W)};
    nxt_acc = acc_ff;
    if (i_update) begin
      nxt_acc = ACC_W'(acc_ff + step[ACC_W-1:0]);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  assign o_offset = acc_ff[ACC_W-1 -: SAMPLE_W];
endmodule : ioc_core_lane
`default_nettype wire

// [ioc_corrector.sv]
`timescale 1ns/10ps
`default_nettype none
module ioc_corrector #(
  parameter int SAMPLE_W  = ioc_pkg::SAMPLE_W,
  parameter int NUM_CHAN  = ioc_pkg::NUM_CHAN,
  parameter int NUM_CORES = ioc_pkg::NUM_CORES
) (
  input  wire logic                         i_ref_clk,     // sample clock
  input  wire logic                         i_sys_rst,     // async reset, high
  input  wire logic                         i_page_we,     // page select write strobe
  input  wire logic [7:0]                   i_page_data,   // page value
  input  wire logic                         i_ctrl_we,     // control write strobe
  input  wire logic [15:0]                  i_ctrl_addr,   // control write address
  input  wire logic [7:0]                   i_ctrl_data,   // control write code
  input  wire logic [NUM_CHAN-1:0]          i_valid,       // sample valid per channel
  input  wire logic [NUM_CHAN*SAMPLE_W-1:0] i_sample,      // raw samples, channel A low
  output logic      [NUM_CHAN-1:0]          o_valid,       // corrected sample valid
  output logic      [NUM_CHAN*SAMPLE_W-1:0] o_sample,      // corrected samples
  output logic      [NUM_CHAN-1:0]          o_frozen,      // channel estimate held
  output logic      [NUM_CHAN-1:0]          o_bypassed,    // channel passes raw data
  output logic      [NUM_CHAN*2-1:0]        o_core_idx     // next core expected per channel
);
  // ------------------------------------------------------------
  // page and per-channel mode
  // ------------------------------------------------------------
  logic [7:0]          page_ff;
  logic [7:0]          nxt_page;
  logic [NUM_CHAN-1:0] freeze_ff;
  logic [NUM_CHAN-1:0] nxt_freeze;
  logic [NUM_CHAN-1:0] bypass_ff;
  logic [NUM_CHAN-1:0] nxt_bypass;
  logic                ctrl_hit;

  logic [NUM_CHAN-1:0] chan_sel;
  logic [NUM_CHAN-1:0] wr_freeze;
  logic [NUM_CHAN-1:0] wr_bypass;
  logic [NUM_CHAN-1:0] wr_run;
  logic                code_freeze;
  logic                code_bypass;
  logic                code_run;

  // ------------------------------------------------------------
  // control decode
  // ------------------------------------------------------------
  // the page is read as it stood before this edge, so a page write in
  // the same cycle as a control write only steers the next one
  assign ctrl_hit    = i_ctrl_we && (i_ctrl_addr == ioc_pkg::CORR_CTRL_ADR);
  assign code_freeze = (i_ctrl_data == ioc_pkg::CODE_FREEZE);
  assign code_bypass = (i_ctrl_data == ioc_pkg::CODE_BYPASS);
  assign code_run    = (i_ctrl_data == ioc_pkg::CODE_RUN);
  // unknown codes match none of the three and are dropped silently

  genvar gs;
  generate
    for (gs = 0; gs < NUM_CHAN; gs++) begin : g_sel
      // page values past the last channel select nothing, so a stray write is harmless
      assign chan_sel[gs]  = (page_ff == 8'(gs));
      assign wr_freeze[gs] = ctrl_hit && chan_sel[gs] && code_freeze;
      assign wr_bypass[gs] = ctrl_hit && chan_sel[gs] && code_bypass;
      assign wr_run[gs]    = ctrl_hit && chan_sel[gs] && code_run;
    end
  endgenerate

  // ------------------------------------------------------------
  // page register
  // ------------------------------------------------------------
  always_comb begin
    nxt_page = page_ff;
    if (i_page_we) begin
      nxt_page = i_page_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      page_ff <= ioc_pkg::RST_PAGE;
    end else begin
      page_ff <= nxt_page;
    end
  end

  // ------------------------------------------------------------
  // freeze and bypass per channel
  // ------------------------------------------------------------
  always_comb begin
    // freeze also leaves bypass, so the held estimates apply at once
    nxt_freeze = (freeze_ff & ~wr_run) | wr_freeze;
    nxt_bypass = (bypass_ff & ~wr_run & ~wr_freeze) | wr_bypass;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      freeze_ff <= {NUM_CHAN{ioc_pkg::RST_FREEZE}};
      bypass_ff <= {NUM_CHAN{ioc_pkg::RST_BYPASS}};
    end else begin
      freeze_ff <= nxt_freeze;
      bypass_ff <= nxt_bypass;
    end
  end

  assign o_frozen   = freeze_ff;
  assign o_bypassed = bypass_ff;

  // ------------------------------------------------------------
  // per-channel data path
  // ------------------------------------------------------------
  logic [NUM_CHAN-1:0]          valid_ff;
  logic [NUM_CHAN-1:0]          nxt_valid;
  logic [NUM_CHAN*SAMPLE_W-1:0] out_ff;
  logic [NUM_CHAN*SAMPLE_W-1:0] nxt_out;
  logic [NUM_CHAN*2-1:0]        idx_ff;
  logic [NUM_CHAN*2-1:0]        nxt_idx;
  logic [NUM_CHAN-1:0]          learn;

  // estimation halts only on freeze; bypass keeps learning, so
  // leaving bypass later does not start from a stale estimate
  assign learn = i_valid & ~freeze_ff;

  genvar gc;
  genvar gk;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
      logic [SAMPLE_W-1:0] raw;
      logic [SAMPLE_W-1:0] ofs [NUM_CORES];
      logic [SAMPLE_W-1:0] fixed;
      logic [1:0]          cur;

      assign raw = i_sample[gc*SAMPLE_W +: SAMPLE_W];
      assign cur = idx_ff[gc*2 +: 2];
      // equal core offsets leave no spur at dc, fs/4 or fs/2;
      // wraps on overflow, there is no saturation
      assign fixed = SAMPLE_W'(raw - ofs[cur]);

      // ------------------------------------------------------------
      // one estimate per core
      // ------------------------------------------------------------
      for (gk = 0; gk < NUM_CORES; gk++) begin : g_core
        ioc_core_lane #(
          .SAMPLE_W (SAMPLE_W),
          .FRAC_W   (ioc_pkg::ACC_FRAC_W)
        ) u_lane (
          .i_ref_clk (i_ref_clk),
          .i_sys_rst (i_sys_rst),
          .i_update  (learn[gc] && (cur == 2'(gk))),
          .i_sample  (raw),
          .o_offset  (ofs[gk])
        );
      end

      // ------------------------------------------------------------
      // core rotation
      // ------------------------------------------------------------
      // counts valid samples since reset; a skipped sample would shift
      // every later sample onto the estimate of the wrong core
      always_comb begin
        nxt_idx[gc*2 +: 2] = cur;
        if (i_valid[gc]) begin
          nxt_idx[gc*2 +: 2] = 2'(cur + 2'h1);
        end
      end

      // ------------------------------------------------------------
      // output sample
      // ------------------------------------------------------------
      always_comb begin
        nxt_valid[gc]                    = i_valid[gc];
        nxt_out[gc*SAMPLE_W +: SAMPLE_W] = out_ff[gc*SAMPLE_W +: SAMPLE_W];
        if (i_valid[gc]) begin
          if (bypass_ff[gc]) begin
            nxt_out[gc*SAMPLE_W +: SAMPLE_W] = raw;
          end else begin
            nxt_out[gc*SAMPLE_W +: SAMPLE_W] = fixed;
          end
        end
      end
    end
  endgenerate

  // rotation is kept apart from the data registers: it follows valid
  // only and must never be gated by freeze or bypass
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idx_ff <= {NUM_CHAN{ioc_pkg::RST_CORE_IDX}};
    end else begin
      idx_ff <= nxt_idx;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_ff <= '0;
      out_ff   <= '0;
    end else begin
      valid_ff <= nxt_valid;
      out_ff   <= nxt_out;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_valid    = valid_ff;
  assign o_sample   = out_ff;
  assign o_core_idx = idx_ff;
endmodule : ioc_corrector
`default_nettype wire

// [ioc_corrector_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// port-level checks of the offset corrector
// ------------------------------------------------------------
module ioc_corrector_checker (
  input wire logic        i_ref_clk,   // sample clock
  input wire logic        i_sys_rst,   // async reset, high
  input wire logic        i_page_we,   // page write
  input wire logic [7:0]  i_page_data, // page value
  input wire logic        i_ctrl_we,   // control write
  input wire logic [15:0] i_ctrl_addr, // control address
  input wire logic [7:0]  i_ctrl_data, // control code
  input wire logic [1:0]  i_valid,     // raw valid
  input wire logic [27:0] i_sample,    // raw samples
  input wire logic [1:0]  o_valid,     // corrected valid
  input wire logic [27:0] o_sample,    // corrected samples
  input wire logic [1:0]  o_frozen,    // freeze state
  input wire logic [1:0]  o_bypassed,  // bypass state
  input wire logic [3:0]  o_core_idx   // core rotation
);
  logic [7:0] page_ff;
  logic [7:0] nxt_page;
  logic       hit;
  always_comb nxt_page = i_page_we ? i_page_data : page_ff;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) page_ff <= 8'h00;
    else page_ff <= nxt_page;
  end
  // same-cycle page write is not seen by the control write
  assign hit = i_ctrl_we && i_ctrl_addr == ioc_pkg::CORR_CTRL_ADR && page_ff < 8'h02;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  valid_lat_a: assert property (!$past(i_sys_rst) |-> o_valid == $past(i_valid))
    else $error("valid latency wrong");
  freeze_set_a: assert property (hit && i_ctrl_data == ioc_pkg::CODE_FREEZE |=>
    o_frozen[$past(page_ff[0])] && !o_bypassed[$past(page_ff[0])]) else $error("freeze lost");
  bypass_set_a: assert property (hit && i_ctrl_data == ioc_pkg::CODE_BYPASS |=>
    o_bypassed[$past(page_ff[0])]) else $error("bypass lost");
  run_clear_a: assert property (hit && i_ctrl_data == ioc_pkg::CODE_RUN |=>
    !o_frozen[$past(page_ff[0])] && !o_bypassed[$past(page_ff[0])]) else $error("run lost");
  chan_apart_a: assert property (i_ctrl_we && page_ff == 8'h00 |=>
    $stable({o_frozen[1], o_bypassed[1]})) else $error("channel b disturbed");
  refuse_wr_a: assert property (i_ctrl_we && !hit |=>
    $stable({o_frozen, o_bypassed})) else $error("refused write acted");
  idx_step_a: assert property (i_valid[0] |=>
    o_core_idx[1:0] == $past(o_core_idx[1:0]) + 2'h1) else $error("core index step");
  bypass_raw_a: assert property (o_bypassed[0] && i_valid[0] |=>
    o_sample[13:0] == $past(i_sample[13:0])) else $error("bypass not raw");
endmodule // ioc_corrector_checker
bind ioc_corrector ioc_corrector_checker u_chk (.i_ref_clk, .i_sys_rst, .i_page_we,
  .i_page_data, .i_ctrl_we, .i_ctrl_addr, .i_ctrl_data, .i_valid, .i_sample, .o_valid,
  .o_sample, .o_frozen, .o_bypassed, .o_core_idx);
`default_nettype wire

// [ioc_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// four interleaved cores, each with its own fixed offset
// ------------------------------------------------------------
module ioc_core_model (
  input  wire logic        i_ref_clk, // sample clock
  input  wire logic        i_rst,     // restarts rotation
  input  wire logic        i_en,      // cores delivering
  input  wire logic [27:0] i_sig,     // wanted signal, a low
  output logic      [1:0]  o_valid,   // sample present
  output logic      [27:0] o_sample   // raw core samples
);
  logic [1:0]  core_ff;
  logic [27:0] raw;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) core_ff <= 2'h0;
    else if (i_en) core_ff <= core_ff + 2'h1;
  end
  assign raw = {i_sig[27:14] + 14'h19 - 14'(30 * core_ff), i_sig[13:0] + 14'(40 * core_ff) - 14'h3C};
  assign o_valid = {2{i_en}};
  // idle lines show a changed value, never the last sample
  assign o_sample = i_en ? raw : ~raw;
endmodule // ioc_core_model
`default_nettype wire

// [tb_interleave_offset_corrector.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// freeze, refuse, bypass and run sequence
// ------------------------------------------------------------
module tb_interleave_offset_corrector;
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_page_we = 1'b0, i_ctrl_we = 1'b0;
  logic        en = 1'b0, chk = 1'b0, chk_d = 1'b0;
  logic [7:0]  i_page_data = 8'h00, i_ctrl_data = 8'h00;
  logic [15:0] i_ctrl_addr = 16'h0000;
  logic [27:0] sig = 28'h0, i_sample, o_sample;
  logic [1:0]  i_valid, o_valid, o_frozen, o_bypassed;
  logic [3:0]  o_core_idx;
  logic [27:0] expq[$];
  int          miscompares = 0, num_checks = 0, seed = 27;
  ioc_core_model u_cores (.i_ref_clk, .i_rst(i_sys_rst), .i_en(en), .i_sig(sig),
    .o_valid(i_valid), .o_sample(i_sample));
  ioc_corrector dut (.i_ref_clk, .i_sys_rst, .i_page_we, .i_page_data, .i_ctrl_we,
    .i_ctrl_addr, .i_ctrl_data, .i_valid, .i_sample, .o_valid, .o_sample, .o_frozen,
    .o_bypassed, .o_core_idx);
  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) chk_d <= chk;
  task automatic cmp_smp(input string what, input logic [27:0] exp, input logic [27:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cmp_mode(input string what, input logic [3:0] exp);
    cmp_smp(what, 28'(exp), 28'({o_bypassed, o_frozen}));
    $display("end %s", what);
  endtask
  task automatic wr(input logic [7:0] pg, input logic [15:0] ad, input logic [7:0] cd);
    @(posedge i_ref_clk) #1 chk = 1'b0;
    sig = 28'h0;
    i_page_we = 1'b1;
    i_page_data = pg;
    @(posedge i_ref_clk) #1 i_page_we = 1'b0;
    i_ctrl_we = 1'b1;
    i_ctrl_addr = ad;
    i_ctrl_data = cd;
    @(posedge i_ref_clk) #1 i_ctrl_we = 1'b0;
    @(posedge i_ref_clk) #1;
  endtask
  task automatic drive(input int n, input logic raw_a);
    for (int k = 0; k < n; k++) begin
      @(posedge i_ref_clk) #1 sig = {14'($random(seed) % 256), 14'($random(seed) % 256)};
      chk = 1'b1;
      #1 expq.push_back({sig[27:14], raw_a ? i_sample[13:0] : sig[13:0]});
    end
  endtask
  always @(negedge i_ref_clk) begin
    if (chk_d && o_valid === 2'h3) cmp_smp("sample", expq.pop_front(), o_sample);
  end
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    #1 i_sys_rst = 1'b0;
    en = 1'b1;
    // idle far beyond the minimum so the estimate settles to the last lsb
    repeat (52000) @(posedge i_ref_clk);
    wr(ioc_pkg::PAGE_CHAN_A, ioc_pkg::CORR_CTRL_ADR, ioc_pkg::CODE_FREEZE);
    cmp_mode("freeze a", 4'h1);
    wr(8'h02, ioc_pkg::CORR_CTRL_ADR, ioc_pkg::CODE_FREEZE);
    wr(ioc_pkg::PAGE_CHAN_B, 16'h6069, ioc_pkg::CODE_FREEZE);
    cmp_mode("refused", 4'h1);
    wr(ioc_pkg::PAGE_CHAN_B, ioc_pkg::CORR_CTRL_ADR, ioc_pkg::CODE_FREEZE);
    cmp_mode("freeze b", 4'h3);
    drive(64, 1'b0);
    wr(ioc_pkg::PAGE_CHAN_A, ioc_pkg::CORR_CTRL_ADR, ioc_pkg::CODE_BYPASS);
    cmp_mode("bypass a", 4'h7);
    drive(64, 1'b1);
    wr(ioc_pkg::PAGE_CHAN_A, ioc_pkg::CORR_CTRL_ADR, ioc_pkg::CODE_RUN);
    cmp_mode("run a", 4'h2);
    stop_test();
  end
endmodule // tb_interleave_offset_corrector
`default_nettype wire
